/* File: logic/video_tx_consts.vh */
// Offsets, fields, reset values and levels of the video transmitter port
`ifndef VIDEO_TX_CONSTS_VH
`define VIDEO_TX_CONSTS_VH

// Register indices; AXI byte address is four times the index
`define REG_FMT      8'h1A
`define REG_CTRL     8'h1C
`define REG_AUX      8'h1E
`define REG_STAT     8'h1F
`define REG_SYNC     8'h21

// Control register fields
`define CTRL_EDGE    0
`define CTRL_DUAL    1
`define CTRL_YCC     2
`define CTRL_COMP    3
`define CTRL_SYNCINS 4
`define CTRL_CONV    5
`define CTRL_SRST    7
`define CTRL_RST     8'h00

// Aux register fields
`define AUX_DIR      0
`define AUX_VAL      1
`define AUX_ALERT    2
`define AUX_REL      3
`define AUX_RST      3'h0

// Sync register field
`define SYNC_EN      3
`define SYNC_RST     1'h0

// Pixel formats
`define FMT_15       2'h0
`define FMT_16       2'h1
`define FMT_24       2'h2
`define FMT_30       2'h3
`define FMT_RST      2'h2

// Serial target address high bits
`define ADDR_HI      5'h1D

// DAC levels
`define DAC_MID      10'h200
`define DAC_BLANK    10'h040
`define DAC_TIP      10'h000

// AXI responses
`define RESP_OK      2'h0
`define RESP_ERR     2'h2

`endif

/* File: logic/video_tx_host_port.v */
// Pixel host port with serial and AXI4-Lite control, link and DAC paths
`include "video_tx_consts.vh"

module video_tx_host_port (
  input  wire        i_sys_clk,
  input  wire        i_rst,
  input  wire [11:0] i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  output wire [1:0]  o_bresp,
  output wire        o_bvalid,
  input  wire        i_bready,
  input  wire [11:0] i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output wire [31:0] o_rdata,
  output wire [1:0]  o_rresp,
  output wire        o_rvalid,
  input  wire        i_rready,
  input  wire        i_pixel_clk_in,
  input  wire        i_pixel_clk_in_b,
  input  wire [15:0] i_pixel_data,
  input  wire        i_hsync,
  input  wire        i_vsync,
  input  wire        i_pixel_valid,
  input  wire        i_monitor_sense,
  input  wire        i_addr_pick,
  input  wire        i_reset_pin_n,
  input  wire        i_ctl_link_clk,
  input  wire        i_ctl_link_data,
  output wire        o_ctl_link_data_out,
  output wire        o_ctl_link_data_oe_n,
  input  wire        i_aux0,
  output wire        o_aux0_out,
  output wire        o_aux0_oe_n,
  output wire        o_plug_change_alert,
  output wire        o_plug_change_alert_oe_n,
  output wire        o_link_drv_en,
  output reg         o_link_clk_out,
  output reg  [7:0]  o_link_lane_blue,
  output reg  [7:0]  o_link_lane_green,
  output reg  [7:0]  o_link_lane_red,
  output reg         o_link_valid,
  output reg         o_link_hsync,
  output reg         o_link_vsync,
  output reg  [9:0]  o_dac_y_g,
  output reg  [9:0]  o_red_pr_out,
  output reg  [9:0]  o_blue_pb_out,
  output reg         o_hsync,
  output reg         o_vsync
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_AK0  = 3'h2;
  localparam [2:0] S_ACK  = 3'h3;
  localparam [2:0] S_WR   = 3'h4;
  localparam [2:0] S_RD   = 3'h5;
  localparam [2:0] S_RACK = 3'h6;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  reg  [26:0] meta_q;
  reg  [26:0] sy_q;
  reg  [26:0] prev_q;
  wire [26:0] raw;

  assign raw = {i_pixel_clk_in, i_pixel_clk_in_b, i_pixel_data, i_hsync,
                i_vsync, i_pixel_valid, i_monitor_sense, i_addr_pick,
                i_reset_pin_n, i_ctl_link_clk, i_ctl_link_data, i_aux0};

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_q <= 27'h0000000;
      sy_q   <= 27'h0000000;
      prev_q <= 27'h0000000;
    end else begin
      meta_q <= raw;
      sy_q   <= meta_q;
      prev_q <= sy_q;
    end
  end

  wire        pa_s    = sy_q[26];
  wire        pb_s    = sy_q[25];
  wire [15:0] d_s     = sy_q[24:9];
  wire        hs_s    = sy_q[8];
  wire        vs_s    = sy_q[7];
  wire        de_s    = sy_q[6];
  wire        sense_s = sy_q[5];
  wire        pick_s  = sy_q[4];
  wire        rstn_s  = sy_q[3];
  wire        scl_s   = sy_q[2];
  wire        sda_s   = sy_q[1];
  wire        aux0_s  = sy_q[0];

  wire regs_rst  = i_rst | ~rstn_s;
  // Ignore the false sense edge seen as reset lifts
  wire sense_chg = (sense_s ^ prev_q[5]) & prev_q[3];

  //////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] ctrl_q;
  reg [1:0] fmt_q;
  reg [2:0] aux_q;
  reg       syncen_q;
  reg       alert_q;
  reg       i2c_we_q;
  reg [7:0] i2c_wa_q;
  reg [7:0] i2c_wd_q;
  reg       aw_h_q;
  reg       w_h_q;
  reg [9:0] aw_a_q;
  reg [7:0] wd_q;
  reg       ws_q;
  reg       bvalid_q;
  reg [1:0] bresp_q;
  reg       rvalid_q;
  reg [7:0] rdata_q;
  reg [1:0] rresp_q;

  function mapped;
    input [9:0] idx;
    begin
      mapped = (idx == {2'h0, `REG_FMT}) || (idx == {2'h0, `REG_CTRL}) ||
               (idx == {2'h0, `REG_AUX}) || (idx == {2'h0, `REG_STAT}) ||
               (idx == {2'h0, `REG_SYNC});
    end
  endfunction

  function [7:0] rd_reg;
    input [7:0] idx;
    begin
      if (idx == `REG_CTRL) rd_reg = ctrl_q;
      else if (idx == `REG_FMT) rd_reg = {6'h00, fmt_q};
      else if (idx == `REG_AUX) rd_reg = {5'h00, aux_q};
      else if (idx == `REG_STAT) rd_reg = {5'h00, sense_s, alert_q, aux0_s};
      else if (idx == `REG_SYNC) rd_reg = {4'h0, syncen_q, 3'h0};
      else rd_reg = 8'h00;
    end
  endfunction

  wire       axi_go = aw_h_q & w_h_q & ~bvalid_q & ~i2c_we_q;
  wire       we     = i2c_we_q | (axi_go & ws_q);
  wire [7:0] wa     = i2c_we_q ? i2c_wa_q : aw_a_q[7:0];
  wire [7:0] wd     = i2c_we_q ? i2c_wd_q : wd_q;
  wire       wa_ok  = i2c_we_q | (aw_a_q[9:8] == 2'h0);
  wire       rel    = we & wa_ok & (wa == `REG_AUX) & wd[`AUX_REL];

  always @(posedge i_sys_clk) begin
    if (regs_rst) begin
      ctrl_q   <= `CTRL_RST;
      fmt_q    <= `FMT_RST;
      aux_q    <= `AUX_RST;
      syncen_q <= `SYNC_RST;
      alert_q  <= 1'b0;
    end else begin
      if (we & wa_ok) begin
        if (wa == `REG_CTRL) ctrl_q <= wd;
        else if (wa == `REG_FMT) fmt_q <= wd[1:0];
        else if (wa == `REG_AUX) aux_q <= wd[2:0];
        else if (wa == `REG_SYNC) syncen_q <= wd[`SYNC_EN];
      end
      // Sense change beats a release in the same cycle
      alert_q <= sense_chg | (alert_q & ~rel);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign o_awready = ~aw_h_q & ~bvalid_q;
  assign o_wready  = ~w_h_q & ~bvalid_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = ~rvalid_q;
  assign o_rvalid  = rvalid_q;
  assign o_rresp   = rresp_q;
  assign o_rdata   = {24'h000000, rdata_q};

  always @(posedge i_sys_clk) begin
    if (regs_rst) begin
      aw_h_q   <= 1'b0;
      w_h_q    <= 1'b0;
      aw_a_q   <= 10'h000;
      wd_q     <= 8'h00;
      ws_q     <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OK;
      rvalid_q <= 1'b0;
      rdata_q  <= 8'h00;
      rresp_q  <= `RESP_OK;
    end else begin
      if (i_awvalid & o_awready) begin
        aw_h_q <= 1'b1;
        aw_a_q <= i_awaddr[11:2];
      end
      if (i_wvalid & o_wready) begin
        w_h_q <= 1'b1;
        wd_q  <= i_wdata[7:0];
        ws_q  <= i_wstrb[0];
      end
      if (axi_go) begin
        aw_h_q   <= 1'b0;
        w_h_q    <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= mapped(aw_a_q) ? `RESP_OK : `RESP_ERR;
      end else if (bvalid_q & i_bready) begin
        bvalid_q <= 1'b0;
      end
      if (i_arvalid & o_arready) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_reg(i_araddr[9:2]) & {8{i_araddr[11:10] == 2'h0}};
        rresp_q  <= mapped(i_araddr[11:2]) ? `RESP_OK : `RESP_ERR;
      end else if (rvalid_q & i_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Two-wire serial target

  reg  [2:0] st_q;
  reg  [2:0] bit_q;
  reg  [7:0] sh_q;
  reg  [7:0] ptr_q;
  reg        rw_q;
  reg        first_q;
  reg        drv_q;
  wire       scl_rise = scl_s & ~prev_q[2];
  wire       scl_fall = ~scl_s & prev_q[2];
  wire       start    = scl_s & prev_q[2] & prev_q[1] & ~sda_s;
  wire       stop     = scl_s & prev_q[2] & ~prev_q[1] & sda_s;
  wire [7:0] byte_in  = {sh_q[6:0], sda_s};
  wire [7:0] rd_byte  = rd_reg(ptr_q);

  assign o_ctl_link_data_out  = 1'b0;
  assign o_ctl_link_data_oe_n = ~drv_q;

  always @(posedge i_sys_clk) begin
    if (regs_rst) begin
      st_q     <= S_IDLE;
      bit_q    <= 3'h0;
      sh_q     <= 8'h00;
      ptr_q    <= 8'h00;
      rw_q     <= 1'b0;
      first_q  <= 1'b0;
      drv_q    <= 1'b0;
      i2c_we_q <= 1'b0;
      i2c_wa_q <= 8'h00;
      i2c_wd_q <= 8'h00;
    end else begin
      i2c_we_q <= 1'b0;
      if (stop) begin
        st_q  <= S_IDLE;
        drv_q <= 1'b0;
      end else if (start) begin
        st_q    <= S_ADDR;
        bit_q   <= 3'h0;
        first_q <= 1'b1;
        drv_q   <= 1'b0;
      end else if (scl_rise) begin
        case (st_q)
          S_ADDR: begin
            sh_q  <= byte_in;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              if (byte_in[7:1] == {`ADDR_HI, ~pick_s, pick_s}) begin
                rw_q <= byte_in[0];
                st_q <= S_AK0;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_WR: begin
            sh_q  <= byte_in;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_q    <= S_AK0;
              first_q <= 1'b0;
              if (first_q) begin
                ptr_q <= byte_in;
              end else begin
                i2c_we_q <= 1'b1;
                i2c_wa_q <= ptr_q;
                i2c_wd_q <= byte_in;
                ptr_q    <= ptr_q + 8'h01;
              end
            end
          end
          S_RD: begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) st_q <= S_RACK;
          end
          S_RACK: begin
            if (sda_s) begin
              st_q <= S_IDLE;
            end else begin
              st_q  <= S_ACK;
              ptr_q <= ptr_q + 8'h01;
            end
          end
          default: begin
            st_q <= st_q;
          end
        endcase
      end else if (scl_fall) begin
        case (st_q)
          S_AK0: begin
            drv_q <= 1'b1;
            st_q  <= S_ACK;
          end
          S_ACK: begin
            bit_q <= 3'h0;
            if (rw_q) begin
              st_q  <= S_RD;
              sh_q  <= {rd_byte[6:0], 1'b0};
              drv_q <= ~rd_byte[7];
            end else begin
              st_q  <= S_WR;
              drv_q <= 1'b0;
            end
          end
          S_RD: begin
            drv_q <= ~sh_q[7];
            sh_q  <= {sh_q[6:0], 1'b0};
          end
          S_RACK: begin
            drv_q <= 1'b0;
          end
          default: begin
            drv_q <= drv_q;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Aux pins

  assign o_aux0_out  = aux_q[`AUX_VAL];
  assign o_aux0_oe_n = ~aux_q[`AUX_DIR];
  assign o_plug_change_alert      = 1'b0;
  assign o_plug_change_alert_oe_n = ~(alert_q & aux_q[`AUX_ALERT]);
  assign o_link_drv_en = sense_s;

  //////////////////////////////////////////////////////////////////////////
  // Pixel capture

  function [9:0] clamp10;
    input integer v;
    begin
      if (v < 0) clamp10 = 10'h000;
      else if (v > 1023) clamp10 = 10'h3FF;
      else clamp10 = v[9:0];
    end
  endfunction

  function [29:0] unpack;
    input [1:0]  fmt;
    input [31:0] w;
    begin
      case (fmt)
        `FMT_15: unpack = {w[14:10], 5'h00, w[9:5], 5'h00, w[4:0], 5'h00};
        `FMT_16: unpack = {w[15:11], 5'h00, w[10:5], 4'h0, w[4:0], 5'h00};
        `FMT_24: unpack = {w[23:16], 2'h0, w[15:8], 2'h0, w[7:0], 2'h0};
        default: unpack = w[29:0];
      endcase
    end
  endfunction

  function [29:0] ycc2rgb;
    input [29:0] p;
    integer y, cr, cb;
    begin
      y  = p[19:10];
      cr = p[29:20] - 512;
      cb = p[9:0] - 512;
      ycc2rgb = {clamp10(y + cr + (cr >>> 2) + (cr >>> 3)),
                 clamp10(y - (cb >>> 2) - (cr >>> 1) - (cr >>> 3)),
                 clamp10(y + cb + (cb >>> 1) + (cb >>> 2))};
    end
  endfunction

  function [29:0] rgb2ypp;
    input [29:0] p;
    integer r, g, b, y;
    begin
      r = p[29:20];
      g = p[19:10];
      b = p[9:0];
      y = (2 * r + 5 * g + b) >>> 3;
      rgb2ypp = {clamp10(((r - y) >>> 1) + 512), clamp10(y),
                 clamp10(((b - y) >>> 1) + 512)};
    end
  endfunction

  reg         lvl_q;
  reg         lvl_d;
  reg         half_q;
  reg  [15:0] lo_q;
  reg  [31:0] pix_q;
  reg  [2:0]  ctl_q;
  reg         stb_q;
  wire        dp_rst = regs_rst | ctrl_q[`CTRL_SRST];
  wire        rise   = lvl_d & ~lvl_q;
  wire        fall   = ~lvl_d & lvl_q;
  wire        sel    = ctrl_q[`CTRL_EDGE] ? fall : rise;
  wire        dual   = ctrl_q[`CTRL_DUAL];
  wire        take   = dual ? (rise | fall) : sel;
  wire        first  = dual ? sel : ~half_q;
  wire        de_up  = de_s & ~prev_q[6];

  // Differential receiver with hold when both legs agree
  always @* begin
    case ({pa_s, pb_s})
      2'b10:   lvl_d = 1'b1;
      2'b01:   lvl_d = 1'b0;
      default: lvl_d = lvl_q;
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (dp_rst) begin
      lvl_q  <= 1'b0;
      half_q <= 1'b0;
      lo_q   <= 16'h0000;
      pix_q  <= 32'h00000000;
      ctl_q  <= 3'h0;
      stb_q  <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      stb_q <= 1'b0;
      if (take) begin
        if (first & ~(de_up & ~dual)) begin
          lo_q   <= d_s;
          half_q <= 1'b1;
        end else begin
          pix_q  <= {d_s, lo_q};
          ctl_q  <= {hs_s, vs_s, de_s};
          half_q <= 1'b0;
          stb_q  <= 1'b1;
        end
      end else if (de_up & ~dual) begin
        half_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Link and analog outputs, one pixel per stb_q

  wire        ycc  = ctrl_q[`CTRL_YCC];
  wire [29:0] up   = unpack(ycc ? `FMT_24 : fmt_q, pix_q);
  wire [29:0] rgb  = (ycc & ctrl_q[`CTRL_CONV]) ? ycc2rgb(up) : up;
  wire [29:0] ypp  = ycc ? {up[19:10], up[29:20], up[9:0]} : rgb2ypp(rgb);
  wire        comp = ctrl_q[`CTRL_COMP];
  wire        sync = ctl_q[2] | ctl_q[1];
  wire        tip  = comp & ctrl_q[`CTRL_SYNCINS] & ctl_q[2];
  wire [9:0]  chb  = comp ? `DAC_MID : `DAC_TIP;

  always @(posedge i_sys_clk) begin
    if (dp_rst) begin
      o_link_clk_out    <= 1'b0;
      o_link_lane_blue  <= 8'h00;
      o_link_lane_green <= 8'h00;
      o_link_lane_red   <= 8'h00;
      o_link_valid      <= 1'b0;
      o_link_hsync      <= 1'b0;
      o_link_vsync      <= 1'b0;
      o_dac_y_g         <= 10'h000;
      o_red_pr_out      <= 10'h000;
      o_blue_pb_out     <= 10'h000;
      o_hsync           <= 1'b0;
      o_vsync           <= 1'b0;
    end else begin
      o_hsync <= hs_s & syncen_q;
      o_vsync <= vs_s & syncen_q;
      if (~sense_s) begin
        o_link_clk_out    <= 1'b0;
        o_link_lane_blue  <= 8'h00;
        o_link_lane_green <= 8'h00;
        o_link_lane_red   <= 8'h00;
        o_link_valid      <= 1'b0;
      end else if (stb_q) begin
        o_link_clk_out    <= ~o_link_clk_out;
        o_link_lane_blue  <= rgb[9:2];
        o_link_lane_green <= rgb[19:12];
        o_link_lane_red   <= rgb[29:22];
        o_link_valid      <= ctl_q[0];
        o_link_hsync      <= ctl_q[2];
        o_link_vsync      <= ctl_q[1];
      end
      if (stb_q) begin
        if (sync) begin
          o_dac_y_g     <= tip ? `DAC_TIP : `DAC_BLANK;
          o_red_pr_out  <= chb;
          o_blue_pb_out <= chb;
        end else if (comp) begin
          o_dac_y_g     <= ypp[19:10];
          o_red_pr_out  <= ypp[29:20];
          o_blue_pb_out <= ypp[9:0];
        end else begin
          o_dac_y_g     <= rgb[19:10];
          o_red_pr_out  <= rgb[29:20];
          o_blue_pb_out <= rgb[9:0];
        end
      end
    end
  end

endmodule // video_tx_host_port

/* File: tb/video_tx_chk.sv */
// Port checker for the video transmitter host port
module video_tx_chk (
  input logic        i_sys_clk,
  input logic        i_rst,
  input logic        i_arvalid,
  input logic        o_arready,
  input logic        i_bready,
  input logic        o_bvalid,
  input logic        i_rready,
  input logic        o_rvalid,
  input logic [31:0] o_rdata,
  input logic        i_hsync,
  input logic        i_monitor_sense,
  input logic        i_reset_pin_n,
  input logic        o_ctl_link_data_out,
  input logic        o_ctl_link_data_oe_n,
  input logic        o_plug_change_alert,
  input logic        o_plug_change_alert_oe_n,
  input logic        o_link_drv_en,
  input logic        o_link_clk_out,
  input logic [7:0]  o_link_lane_blue,
  input logic [7:0]  o_link_lane_red,
  input logic        o_hsync
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  a_alert_open_drain: assert property (o_plug_change_alert == 1'b0)
    else $error("alert pin driven high");
  a_ctl_data_od: assert property (o_ctl_link_data_out == 1'b0)
    else $error("serial data driven high");
  a_sense_off_link: assert property ($fell(i_monitor_sense) |-> ##[1:4] !o_link_drv_en)
    else $error("link drivers stay on without monitor");
  a_sense_on_link: assert property ($rose(i_monitor_sense) |-> ##[1:4] o_link_drv_en)
    else $error("link drivers stay off with monitor");
  a_link_quiet_off: assert property (!o_link_drv_en [*2] |->
    o_link_lane_blue == 8'h00 && o_link_lane_red == 8'h00 && !o_link_clk_out)
    else $error("link active while drivers off");
  a_pin_reset_hold: assert property (!i_reset_pin_n [*5] |->
    !o_bvalid && !o_rvalid && o_link_lane_blue == 8'h00)
    else $error("activity while reset pin low");
  a_sync_out_copy: assert property (o_hsync |->
    $past(i_hsync, 2) || $past(i_hsync, 3) || $past(i_hsync, 4) || $past(i_hsync, 5))
    else $error("sync output without sync input");
  a_bvalid_stands: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped early");
  a_read_answer: assert property (i_arvalid && o_arready |=>
    o_rvalid && o_rdata[31:8] == 24'h000000)
    else $error("read answer late or wide");
  ////////////////////////////////////////
  c_write_done: cover property (o_bvalid && i_bready);
  c_read_done: cover property (o_rvalid && i_rready);
  c_alert_pull: cover property ($fell(o_plug_change_alert_oe_n));
  c_serial_ack: cover property ($fell(o_ctl_link_data_oe_n));
endmodule // video_tx_chk

bind video_tx_host_port video_tx_chk chk (.*);

/* File: tb/video_src_model.sv */
// Graphics controller pixel source driving the multiplexed pixel bus
module video_src_model (
  output logic        o_pclk,
  output logic        o_pclk_b,
  output logic [15:0] o_data,
  output logic        o_hsync,
  output logic        o_vsync,
  output logic        o_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_pclk = 1'b0;
    o_pclk_b = 1'b1;
    o_data = 16'hFFFF;
    o_hsync = 1'b0;
    o_vsync = 1'b0;
    o_valid = 1'b0;
  end
  ////////////////////////////////////////
  task clk_to(input logic lvl);
    begin
      o_pclk = lvl;    // Differential pair
      o_pclk_b = ~lvl;
    end
  endtask
  task send(input [31:0] w, input logic dual);
    begin
      #10 o_valid = 1'b1;  // Off the sampling edge
      o_data = w[15:0];
      #100 clk_to(1'b1);
      if (dual) begin      // One pixel per 400 ns period
        #100 o_data = w[31:16];
        #100 clk_to(1'b0);
      end else begin       // 400 ns period, 200 ns per phase
        #200 clk_to(1'b0);
        #100 o_data = w[31:16];
        #100 clk_to(1'b1);
        #200 clk_to(1'b0);
      end
      #100 o_valid = 1'b0;
      o_data = ~w[31:16];  // Released bus shows no stale data
    end
  endtask
  task set_sync(input logic h, input logic v);
    begin
      #10 o_hsync = h;
      o_vsync = v;
    end
  endtask
endmodule // video_src_model

/* File: tb/video_transmitter_host_port_test.sv */
// Register, serial, pixel and sense tests of the video transmitter host port
`include "video_tx_consts.vh"
module video_transmitter_host_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk = 1'b0, i_rst = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic        i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0, sda_low = 1'b0;
  logic        i_monitor_sense = 1'b1, i_addr_pick = 1'b1, i_reset_pin_n = 1'b1;
  logic        i_ctl_link_clk = 1'b1;
  logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0]  i_wstrb = 4'h0;
  wire         i_pixel_clk_in, i_pixel_clk_in_b, i_hsync, i_vsync, i_pixel_valid;
  wire  [15:0] i_pixel_data;
  wire         i_ctl_link_data, i_aux0, o_awready, o_wready, o_bvalid, o_arready;
  wire         o_rvalid, o_ctl_link_data_out, o_ctl_link_data_oe_n, o_aux0_out, o_aux0_oe_n;
  wire         o_plug_change_alert, o_plug_change_alert_oe_n, o_link_drv_en, o_link_clk_out;
  wire         o_link_valid, o_link_hsync, o_link_vsync, o_hsync, o_vsync;
  wire  [1:0]  o_bresp, o_rresp;
  wire  [31:0] o_rdata;
  wire  [7:0]  o_link_lane_blue, o_link_lane_green, o_link_lane_red;
  wire  [9:0]  o_dac_y_g, o_red_pr_out, o_blue_pb_out;
  int          n_fail = 0, compares = 0;
  // Pulled-up wires: serial data and aux pin 0
  assign i_ctl_link_data = ~sda_low & (o_ctl_link_data_oe_n | o_ctl_link_data_out);
  assign i_aux0 = o_aux0_oe_n | o_aux0_out;
  always #25 i_sys_clk = ~i_sys_clk;
  video_tx_host_port uut (.*);
  video_src_model src (.o_pclk(i_pixel_clk_in), .o_pclk_b(i_pixel_clk_in_b),
    .o_data(i_pixel_data), .o_hsync(i_hsync), .o_vsync(i_vsync), .o_valid(i_pixel_valid));
  ////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares++;
      if (seen !== exp) begin
        n_fail++;
        $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      if (n_fail == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task axi_wr(input [7:0] idx, input [7:0] d, input [1:0] er);
    logic a, w, b;
    begin
      a = 0;
      w = 0;
      b = 0;
      @(posedge i_sys_clk);
      i_awaddr <= {2'h0, idx, 2'h0};
      i_wdata <= {24'h0, d};
      i_wstrb <= 4'hF;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      while (!b) begin
        @(posedge i_sys_clk);
        if (!a && o_awready === 1'b1) begin
          a = 1;
          i_awvalid <= 1'b0;
        end
        if (!w && o_wready === 1'b1) begin
          w = 1;
          i_wvalid <= 1'b0;
        end
        b = (o_bvalid === 1'b1);
      end
      i_bready <= 1'b0;
      chk(o_bresp, er);
    end
  endtask
  task axi_rd(input [7:0] idx, input [7:0] exp, input [1:0] er);
    logic a, r;
    begin
      a = 0;
      r = 0;
      @(posedge i_sys_clk);
      i_araddr <= {2'h0, idx, 2'h0};
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      while (!r) begin
        @(posedge i_sys_clk);
        if (!a && o_arready === 1'b1) begin
          a = 1;
          i_arvalid <= 1'b0;
        end
        r = (o_rvalid === 1'b1);
      end
      i_rready <= 1'b0;
      chk(o_rdata, {24'h0, exp});
      chk(o_rresp, er);
    end
  endtask
  task half;
    settle(10);
  endtask
  task s_byte(input [7:0] b, output logic ack);
    begin
      for (int i = 7; i >= 0; i--) begin
        sda_low <= ~b[i];
        half;
        i_ctl_link_clk <= 1'b1;
        half;
        i_ctl_link_clk <= 1'b0;
        half;
      end
      sda_low <= 1'b0;
      half;
      i_ctl_link_clk <= 1'b1;
      half;
      ack = ~i_ctl_link_data;
      i_ctl_link_clk <= 1'b0;
      half;
    end
  endtask
  task s_write(input [7:0] adr, input [7:0] ptr, input [7:0] d, input logic exp_ack);
    logic k;
    begin
      sda_low <= 1'b1;
      half;
      i_ctl_link_clk <= 1'b0;
      half;
      s_byte(adr, k);
      chk(k, exp_ack);
      if (k) begin
        s_byte(ptr, k);
        s_byte(d, k);
      end
      s_stop;
    end
  endtask
  task s_stop;
    begin
      sda_low <= 1'b1;
      half;
      i_ctl_link_clk <= 1'b1;
      half;
      sda_low <= 1'b0;
      half;
    end
  endtask
  task s_read(input [7:0] ptr, input [7:0] exp);
    logic k;
    logic [7:0] v;
    begin
      sda_low <= 1'b1;
      half;
      i_ctl_link_clk <= 1'b0;
      half;
      s_byte({`ADDR_HI, 2'b10, 1'b0}, k);
      s_byte(ptr, k);
      i_ctl_link_clk <= 1'b1;
      half;
      sda_low <= 1'b1;
      half;
      i_ctl_link_clk <= 1'b0;
      half;
      s_byte({`ADDR_HI, 2'b10, 1'b1}, k);
      for (int i = 7; i >= 0; i--) begin
        i_ctl_link_clk <= 1'b1;
        half;
        v[i] = i_ctl_link_data;
        i_ctl_link_clk <= 1'b0;
        half;
      end
      i_ctl_link_clk <= 1'b1;
      half;
      i_ctl_link_clk <= 1'b0;
      half;
      s_stop;
      chk({k, v}, {1'b1, exp});
    end
  endtask
  task pix(input [7:0] ctrl, input [7:0] fmt, input [31:0] w, input [23:0] exp);
    begin
      axi_wr(`REG_CTRL, ctrl, `RESP_OK);
      axi_wr(`REG_FMT, fmt, `RESP_OK);
      src.send(w, ctrl[`CTRL_DUAL]);
      settle(12);
      chk({o_link_valid, o_link_lane_red, o_link_lane_green, o_link_lane_blue},
          {1'b1, exp});
    end
  endtask
  task dac(input [7:0] ctrl, input [29:0] exp);
    begin
      axi_wr(`REG_CTRL, ctrl, `RESP_OK);
      src.send(32'h0, 1'b0);
      settle(12);
      chk({o_dac_y_g, o_red_pr_out, o_blue_pb_out}, exp);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    #2000000;
    n_fail++;
    summarize;
  end
  initial begin
    settle(20);
    i_rst <= 1'b0;
    settle(4);
    axi_rd(`REG_FMT, `FMT_RST, `RESP_OK);
    axi_rd(`REG_CTRL, `CTRL_RST, `RESP_OK);
    axi_rd(`REG_AUX, `AUX_RST, `RESP_OK);
    axi_rd(`REG_SYNC, `SYNC_RST, `RESP_OK);
    axi_rd(`REG_STAT, 8'h05, `RESP_OK);
    axi_wr(8'h10, 8'h55, `RESP_ERR);
    axi_rd(8'h10, 8'h00, `RESP_ERR);
    axi_wr(`REG_STAT, 8'h00, `RESP_OK);
    axi_rd(`REG_STAT, 8'h05, `RESP_OK);
    s_write({`ADDR_HI, i_addr_pick, ~i_addr_pick, 1'b0}, `REG_SYNC, 8'h08, 1'b0);
    i_addr_pick <= 1'b0;
    s_write({`ADDR_HI, 2'b10, 1'b0}, `REG_SYNC, 8'h08, 1'b1);
    axi_rd(`REG_SYNC, 8'h08, `RESP_OK);
    s_read(`REG_SYNC, 8'h08);
    src.set_sync(1'b1, 1'b1);
    settle(8);
    chk({o_hsync, o_vsync}, 2'h3);
    dac(8'h08, {`DAC_BLANK, `DAC_MID, `DAC_MID});
    dac(8'h18, {`DAC_TIP, `DAC_MID, `DAC_MID});
    dac(8'h00, {`DAC_BLANK, 20'h0});
    axi_wr(`REG_SYNC, 8'h00, `RESP_OK);
    settle(8);
    chk({o_hsync, o_vsync}, 2'h0);
    src.set_sync(1'b0, 1'b0);
    pix(8'h00, `FMT_24, 32'h00A1B2C3, 24'hA1B2C3);
    pix(8'h01, `FMT_24, 32'h00123456, 24'h123456);
    pix(8'h02, `FMT_24, 32'h005A6B7C, 24'h5A6B7C);
    pix(8'h00, `FMT_30, {2'h0, 10'h3C5, 10'h12A, 10'h0FF}, 24'hF14A3F);
    pix(8'h24, `FMT_24, 32'h00804080, 24'h404040);
    i_monitor_sense <= 1'b0;
    settle(8);
    chk({o_link_drv_en, o_link_lane_blue, o_plug_change_alert_oe_n}, 10'h001);
    axi_rd(`REG_STAT, 8'h03, `RESP_OK);
    axi_wr(`REG_AUX, 8'h04, `RESP_OK);
    settle(2);
    chk(o_plug_change_alert_oe_n, 1'b0);
    axi_wr(`REG_AUX, 8'h0C, `RESP_OK);
    settle(2);
    chk(o_plug_change_alert_oe_n, 1'b1);
    axi_rd(`REG_AUX, 8'h04, `RESP_OK);
    i_monitor_sense <= 1'b1;
    settle(8);
    chk({o_link_drv_en, o_plug_change_alert_oe_n}, 2'h2);
    axi_wr(`REG_AUX, 8'h05, `RESP_OK);
    settle(4);
    chk({o_aux0_oe_n, o_aux0_out}, 2'h0);
    axi_rd(`REG_STAT, 8'h06, `RESP_OK);
    axi_wr(`REG_AUX, 8'h07, `RESP_OK);
    settle(4);
    axi_rd(`REG_STAT, 8'h07, `RESP_OK);
    axi_wr(`REG_SYNC, 8'h08, `RESP_OK);
    i_reset_pin_n <= 1'b0;
    settle(6);
    i_reset_pin_n <= 1'b1;
    settle(4);
    axi_rd(`REG_SYNC, `SYNC_RST, `RESP_OK);
    summarize;
  end
endmodule // video_transmitter_host_port_test
